// [hdl/fas_regs.svh]
// Register offsets, field positions and reset values of the audio port
`ifndef FAS_REGS_SVH
`define FAS_REGS_SVH
`define FAS_CTRL_OFS 8'h00
`define FAS_STAT_OFS 8'h04
`define FAS_TXD_OFS 8'h08
`define FAS_RXL_OFS 8'h0c
`define FAS_RXR_OFS 8'h10
`define FAS_CTRL_EN 0
`define FAS_CTRL_MST 1
`define FAS_CTRL_TXE 2
`define FAS_CTRL_WL 4:3
`define FAS_CTRL_FMT 7:5
`define FAS_CTRL_DIV 15:8
`define FAS_CTRL_RST 32'h0000_0428
`define FAS_ST_RXRDY 0
`define FAS_ST_OVR 1
`define FAS_ST_UDR 2
`define FAS_ST_FULL 3
`define FAS_ST_EMPTY 4
`define FAS_ST_BUSY 5
`define FAS_FIFO_DEPTH 16
`define FAS_RESP_OK 2'b00
`define FAS_RESP_ERR 2'b10
`endif

// [hdl/fas_pkg.sv]
// Types and helper functions shared by the audio port files
`default_nettype none
package fas_pkg;
  typedef enum logic [2:0] {
    FAS_FMT_MSBJ, FAS_FMT_I2S, FAS_FMT_PULSE, FAS_FMT_DPULSE, FAS_FMT_LSBJ
  } fas_fmt_t;

  typedef struct packed {
    logic [7:0] div;
    fas_fmt_t fmt;
    logic [1:0] wlen;
    logic txEn;
    logic master;
  } fas_cfg_t;

  typedef struct packed {
    logic sck;
    logic ws;
    logic sd;
  } fas_line_t;

  // Word length code 0..3 gives 8, 16, 24 or 32 bits
  function automatic logic [6:0] fas_bits(input logic [1:0] wlen);
    fas_bits = 7'({2'b00, wlen, 3'b000}) + 7'h08;
  endfunction : fas_bits

  // Sign extend the low n bits of a word
  function automatic logic [31:0] fas_sext(input logic [31:0] w,
                                           input logic [6:0] n);
    logic [5:0] s;
    s = 6'(7'h20 - n);
    fas_sext = 32'($signed(w << s) >>> s);
  endfunction : fas_sext
endpackage : fas_pkg
`default_nettype wire

// [hdl/fas_sync.sv]
// Two flip-flop synchroniser for the serial line inputs
`default_nettype none
module fas_sync
  import fas_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire fas_line_t lineIn,
  output fas_line_t lineOut
);
  fas_line_t meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      lineOut <= '0;
    end
    else if (ce)
    begin
      meta_r <= lineIn;
      lineOut <= meta_r;
    end
  end
endmodule : fas_sync
`default_nettype wire

// [hdl/fas_fifo.sv]
// Transmit word FIFO with valid/ready on both sides
`include "fas_regs.svh"
`default_nettype none
module fas_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `FAS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic push, pop;

  // Extra pointer bit tells full from empty
  assign outValid = wp_r != rp_r;
  assign inReady = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign outData = mem[rp_r[AW-1:0]];
  assign push = ce && inValid && inReady;
  assign pop = ce && outReady && outValid;

  // Storage has no reset; only the pointers define contents
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= inData;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule : fas_fifo
`default_nettype wire

// [hdl/fas_audio_port.sv]
// Serial digital audio port with AXI4-Lite register access
`include "fas_regs.svh"
`default_nettype none
module fas_audio_port
  import fas_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic wsIn,
  output logic wsOut,
  output logic wsOe,
  input wire logic sdIn,
  output logic sdOut,
  output logic sdOe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  fas_cfg_t cfg_r;
  fas_line_t lineS;
  fas_line_t linePin;
  logic en_r, rxRdy_r, ovr_r, udr_r, awHave_r, wHave_r;
  logic [7:0] awAddr_r, divCnt_r;
  logic [31:0] wData_r, rxL_r, rxR_r, sh_r, txSh_r, fifoData;
  logic [3:0] wStrb_r;
  logic [6:0] nB, pCnt_r, pos_r, posNew;
  logic fifoInReady, fifoValid, wrGo, isTxd, wrMapped, rdRxr;
  logic isMst, tick, riseEv, fallEv, sckD_r, wsPrev_r, chan_r, synced_r;
  logic wsSmp, pulseFmt, dly, slotStart, done, doneLeft, txOk, txRun_r;
  logic loadEv, leftStart, clrRdy, setRdy;
  logic [31:0] doneWord;

  assign nB = fas_bits(cfg_r.wlen);
  assign isMst = en_r && cfg_r.master;
  assign pulseFmt = cfg_r.fmt inside {FAS_FMT_PULSE, FAS_FMT_DPULSE};
  assign dly = cfg_r.fmt inside {FAS_FMT_I2S, FAS_FMT_DPULSE};
  // Transmit only in the two formats the link guarantees
  assign txOk = en_r && cfg_r.txEn && dly;

  // Write channel: address and data are taken in either order
  assign isTxd = awAddr_r == `FAS_TXD_OFS;
  assign wrMapped = awAddr_r inside {`FAS_CTRL_OFS, `FAS_STAT_OFS,
                                     `FAS_TXD_OFS};
  // A push to a full FIFO stalls the bus response, not the data
  assign wrGo = ce && awHave_r && wHave_r && !bvalid &&
                !(isTxd && !fifoInReady);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= `FAS_RESP_OK;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awHave_r <= 1'b1;
        awready <= 1'b0;
        awAddr_r <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wHave_r <= 1'b1;
        wready <= 1'b0;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (wrGo)
      begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrMapped ? `FAS_RESP_OK : `FAS_RESP_ERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Control register; role, length and format lock while enabled
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      en_r <= 1'(`FAS_CTRL_RST & 32'h1);
      cfg_r <= fas_cfg_t'(15'(`FAS_CTRL_RST >> 1));
    end
    else if (wrGo && awAddr_r == `FAS_CTRL_OFS)
    begin
      if (wStrb_r[0])
        en_r <= wData_r[`FAS_CTRL_EN];
      if (!en_r && wStrb_r[0])
      begin
        cfg_r.master <= wData_r[`FAS_CTRL_MST];
        cfg_r.txEn <= wData_r[`FAS_CTRL_TXE];
        cfg_r.wlen <= wData_r[`FAS_CTRL_WL];
        cfg_r.fmt <= fas_fmt_t'(wData_r[`FAS_CTRL_FMT]);
      end
      if (!en_r && wStrb_r[1])
        cfg_r.div <= wData_r[`FAS_CTRL_DIV];
    end
  end

  // Read channel answers one cycle after the address is taken
  assign rdRxr = ce && arvalid && arready && araddr[7:2] == 6'h04;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FAS_RESP_OK;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `FAS_RESP_OK;
        unique case ({araddr[7:2], 2'b00})
          `FAS_CTRL_OFS: rdata <= {16'h0000, cfg_r.div, cfg_r.fmt,
                                   cfg_r.wlen, cfg_r.txEn, cfg_r.master,
                                   en_r};
          `FAS_STAT_OFS: rdata <= {26'h0, synced_r, !fifoValid,
                                   !fifoInReady, udr_r, ovr_r, rxRdy_r};
          `FAS_RXL_OFS: rdata <= rxL_r;
          `FAS_RXR_OFS: rdata <= rxR_r;
          default:
          begin
            rdata <= '0;
            rresp <= `FAS_RESP_ERR;
          end
        endcase
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  fas_fifo #(.WIDTH(32), .DEPTH(`FAS_FIFO_DEPTH)) txFifo (
    .clk(clk), .reset(reset), .ce(ce),
    .inValid(wrGo && isTxd), .inReady(fifoInReady), .inData(wData_r),
    .outValid(fifoValid), .outReady(loadEv), .outData(fifoData)
  );

  // Pins gathered into one word before the two sync stages
  assign linePin = '{sck: sckIn, ws: wsIn, sd: sdIn};

  fas_sync lineSync (
    .clk(clk), .reset(reset), .ce(ce),
    .lineIn(linePin), .lineOut(lineS)
  );

  // Bit clock edges: own divider in master, found edges in slave
  assign tick = isMst && divCnt_r == cfg_r.div;
  assign riseEv = ce && en_r && (cfg_r.master ? tick && !sckOut
                                              : lineS.sck && !sckD_r);
  assign fallEv = ce && en_r && (cfg_r.master ? tick && sckOut
                                              : !lineS.sck && sckD_r);

  // Master clock divider; half period is div+1 cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      divCnt_r <= '0;
      sckOut <= 1'b0;
      sckD_r <= 1'b0;
    end
    else if (ce)
    begin
      sckD_r <= lineS.sck;
      if (!isMst)
      begin
        divCnt_r <= '0;
        sckOut <= 1'b0;
      end
      else if (tick)
      begin
        divCnt_r <= '0;
        sckOut <= !sckOut;
      end
      else
        divCnt_r <= divCnt_r + 8'h01;
    end
  end

  // Master frame of 2N periods; word select moves on the falling edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pCnt_r <= '0;
      wsOut <= 1'b0;
    end
    else if (ce && !isMst)
    begin
      pCnt_r <= 7'((nB << 1) - 7'h01);
      wsOut <= 1'b0;
    end
    else if (fallEv)
    begin
      pCnt_r <= (pCnt_r == 7'((nB << 1) - 7'h01)) ? 7'h00 : pCnt_r + 7'h01;
      if (pulseFmt)
        wsOut <= pCnt_r == 7'((nB << 1) - 7'h01);
      else
        wsOut <= pCnt_r + 7'h01 >= nB && pCnt_r != 7'((nB << 1) - 7'h01);
    end
  end

  // Slot tracking on the rising edge, from own or foreign word select
  assign wsSmp = cfg_r.master ? wsOut : lineS.ws;
  assign slotStart = pulseFmt ? wsSmp && !wsPrev_r : wsSmp != wsPrev_r;
  assign posNew = slotStart ? 7'h00 : (&pos_r ? pos_r : pos_r + 7'h01);
  assign doneLeft = pulseFmt ? posNew == nB - 7'h01 + 7'(dly) : !chan_r;

  // Word completion per alignment format
  always_comb
  begin
    done = 1'b0;
    doneWord = {sh_r[30:0], lineS.sd};
    unique case (cfg_r.fmt)
      FAS_FMT_MSBJ: done = !slotStart && posNew == nB - 7'h01;
      FAS_FMT_I2S: done = pos_r + 7'h01 == nB;
      FAS_FMT_LSBJ:
      begin
        done = slotStart;
        doneWord = sh_r;
      end
      FAS_FMT_PULSE, FAS_FMT_DPULSE:
        done = posNew == nB - 7'h01 + 7'(dly) ||
               posNew == 7'((nB << 1) - 7'h01) + 7'(dly);
      default: done = 1'b0;
    endcase
    done = done && synced_r && riseEv;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wsPrev_r <= 1'b0;
      pos_r <= '0;
      chan_r <= 1'b0;
      synced_r <= 1'b0;
      sh_r <= '0;
    end
    else if (ce && !en_r)
    begin
      synced_r <= 1'b0;
      pos_r <= '0;
    end
    else if (riseEv)
    begin
      wsPrev_r <= wsSmp;
      pos_r <= posNew;
      sh_r <= {sh_r[30:0], lineS.sd};
      if (slotStart)
      begin
        chan_r <= wsSmp;
        synced_r <= 1'b1;
      end
    end
  end

  // Received words, sign extended; reading the right word clears ready
  assign setRdy = done && !doneLeft;
  assign clrRdy = rdRxr;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rxL_r <= '0;
      rxR_r <= '0;
      rxRdy_r <= 1'b0;
      ovr_r <= 1'b0;
      udr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (done && doneLeft)
        rxL_r <= fas_sext(doneWord, nB);
      if (setRdy)
        rxR_r <= fas_sext(doneWord, nB);
      // A new pair in the clearing cycle still counts
      if (setRdy)
        rxRdy_r <= 1'b1;
      else if (clrRdy)
        rxRdy_r <= 1'b0;
      if (setRdy && rxRdy_r && !clrRdy)
        ovr_r <= 1'b1;
      else if (wrGo && awAddr_r == `FAS_STAT_OFS && wData_r[`FAS_ST_OVR])
        ovr_r <= 1'b0;
      if (loadEv && !fifoValid)
        udr_r <= 1'b1;
      else if (wrGo && awAddr_r == `FAS_STAT_OFS && wData_r[`FAS_ST_UDR])
        udr_r <= 1'b0;
    end
  end

  // Transmit loads on the rising edge so the MSB leads one period late
  assign leftStart = slotStart && (pulseFmt || !wsSmp);
  assign loadEv = riseEv && txOk && (txRun_r || leftStart) &&
                  (slotStart || (cfg_r.fmt == FAS_FMT_DPULSE &&
                                 posNew == nB));

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txRun_r <= 1'b0;
      txSh_r <= '0;
      sdOut <= 1'b0;
    end
    else if (ce && !txOk)
    begin
      txRun_r <= 1'b0;
      sdOut <= 1'b0;
    end
    else if (loadEv)
    begin
      txRun_r <= 1'b1;
      // Empty FIFO sends a silent word
      txSh_r <= fifoValid ? 32'(fifoData << 6'(7'h20 - nB)) : '0;
    end
    else if (fallEv)
    begin
      sdOut <= txSh_r[31];
      txSh_r <= txSh_r << 1;
    end
  end

  // Pin drivers follow role and transmit enable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sckOe <= 1'b0;
      wsOe <= 1'b0;
      sdOe <= 1'b0;
    end
    else if (ce)
    begin
      sckOe <= isMst;
      wsOe <= isMst;
      sdOe <= txOk;
    end
  end

  cfg_hold_a: assert property (en_r && $past(en_r) |-> $stable(cfg_r))
    else $error("configuration changed while enabled");
  ws_edge_a: assert property ($changed(wsOut) && $past(isMst) |->
    $past(fallEv)) else $error("word select moved off a falling edge");
  sd_edge_a: assert property ($changed(sdOut) && $past(txOk) |->
    $past(fallEv)) else $error("data moved off a falling edge");
  mst_oe_a: assert property (ce |=> sckOe == $past(isMst) &&
    wsOe == $past(isMst)) else $error("clock drive does not follow role");
  ws_left_a: assert property ($past(fallEv && isMst && !pulseFmt)
    && isMst |-> wsOut == (pCnt_r >= nB))
    else $error("word select level wrong for channel");
  pulse_ws_a: assert property (isMst && pulseFmt && wsOut |->
    pCnt_r == 7'h00) else $error("frame pulse outside first period");
  msb_first_a: assert property (fallEv && txOk && !loadEv |=>
    sdOut == $past(txSh_r[31])) else $error("data bit out of order");
  tx_fmt_a: assert property (ce && !txOk |=> !sdOut)
    else $error("data driven in a receive-only format");
  rx_pair_c: cover property (setRdy && rxRdy_r);
  tx_udr_c: cover property (loadEv && !fifoValid);
  dpulse_c: cover property (loadEv && isMst &&
    cfg_r.fmt == FAS_FMT_DPULSE && !slotStart);
endmodule : fas_audio_port
`default_nettype wire

// [tb/fas_codec_model.sv]
// Behavioural external codec on the serial audio lines
`default_nettype none
module fas_codec_model (
  input wire logic sck,
  input wire logic ws,
  input wire logic sd,
  output logic sckDrv,
  output logic wsDrv,
  output logic sdDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got[$];
  logic [31:0] sh;
  logic wsD;

  // Idle with ws high so the first frame opens on a clean change
  initial
  begin
    sckDrv = 1'b0;
    wsDrv = 1'b1;
    sdDrv = 1'b0;
    sh = 32'h0;
    wsD = 1'b0;
  end

  // Receiver: a word closes when ws changes, LSB already shifted in
  always @(posedge sck)
  begin
    sh = {sh[30:0], sd};
    if (ws !== wsD)
    begin
      got.push_back(sh);
      wsD = ws;
    end
  end

  // Sender: slot of n bits, MSB dl periods after ws moves; clock idles
  task automatic send(input int n, input logic [31:0] l, r, input int fr,
                      input int dl);
    int j;
    int b;
    #7;
    for (int k = 0; k <= 2 * n * fr; k++)
    begin
      j = (k + 2 * n - dl) % (2 * n);
      b = n - 1 - j % n;
      sckDrv = 1'b0;
      wsDrv = (k % (2 * n)) >= n;
      sdDrv = (j >= n) ? r[b] : l[b];
      #200 sckDrv = 1'b1;
      #200;
    end
    sckDrv = 1'b0;
    sdDrv = ~sdDrv; // Inverted line, do not keep last value
  endtask : send
endmodule : fas_codec_model
`default_nettype wire

// [tb/fm_digital_audio_serial_port_tb.sv]
// Self-checking bench for the serial audio port
`include "fas_regs.svh"
`default_nettype none
module fm_digital_audio_serial_port_tb
  import fas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic sckOut, sckOe, wsOut, wsOe, sdOut, sdOe;
  logic mSck, mWs, mSd, sckLine, wsLine, sdLine;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, l, r;
  logic [31:0] pushed[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'h7cf6;
  int n, k;
  fas_fmt_t fm;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Each line follows whichever party enables its driver
  assign sckLine = sckOe ? sckOut : mSck;
  assign wsLine = wsOe ? wsOut : mWs;
  assign sdLine = sdOe ? sdOut : mSd;

  fas_audio_port dut (.clk(clk), .reset(reset), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sckIn(sckLine), .sckOut(sckOut),
    .sckOe(sckOe), .wsIn(wsLine), .wsOut(wsOut), .wsOe(wsOe),
    .sdIn(sdLine), .sdOut(sdOut), .sdOe(sdOe));

  fas_codec_model codec (.sck(sckLine), .ws(wsLine), .sd(sdLine),
    .sckDrv(mSck), .wsDrv(mWs), .sdDrv(mSd));

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic timeout_hit;
    n_mismatch++;
    $display("CHECK FAILED wait expected answer seen none");
    final_report();
  endtask : timeout_hit

  // Write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] resp);
    int t;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 400; t++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (t == 400) timeout_hit();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
    int t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 400; t++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (t == 400) timeout_hit();
  endtask : axr

  function automatic logic [31:0] ctrl(input logic en, mst, tx,
    input logic [1:0] wl, input logic [2:0] fmt);
    ctrl = {16'h0, 8'h04, fmt, wl, tx, mst, en};
  endfunction : ctrl

  // Fields are locked while enabled, so drop enable before changing them
  task automatic setup(input logic [31:0] v);
    axw(`FAS_CTRL_OFS, v & ~32'h1, rs);
    axw(`FAS_CTRL_OFS, v & ~32'h1, rs);
    axw(`FAS_CTRL_OFS, v, rs);
  endtask : setup

  function automatic logic [31:0] sext(input logic [31:0] w, input int n);
    sext = w << (32 - n);
    sext = 32'($signed(sext) >>> (32 - n));
  endfunction : sext

  // Main sequence
  initial
  begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    axr(`FAS_CTRL_OFS, d, rs);
    check("ctrl reset", d, `FAS_CTRL_RST);
    axr(`FAS_STAT_OFS, d, rs);
    check("fifo flags", 32'(d[4:3]), 32'h2);
    axr(8'h14, d, rs);
    check("unmapped read", {d[29:0], rs}, 32'h2);
    axw(8'h14, 32'h5, rs);
    check("unmapped write", 32'(rs), 32'h2);
    $display("test registers done");
    // Slave receive in I2S, MSB- and LSB-justified at every word length
    for (int w = 0; w < 12; w++)
    begin
      n = 8 * (w % 4 + 1);
      fm = (w < 4) ? FAS_FMT_I2S : (w < 8) ? FAS_FMT_MSBJ : FAS_FMT_LSBJ;
      l = $random(seed);
      r = $random(seed);
      setup(ctrl(1'b1, 1'b0, 1'b0, 2'(w % 4), fm));
      codec.send(n, l, r, 2, (fm == FAS_FMT_I2S) ? 1 : 0);
      check("sck oe slave", 32'(sckOe), 32'h0);
      check("ws oe slave", 32'(wsOe), 32'h0);
      repeat (10) @(posedge clk);
      axr(`FAS_RXL_OFS, d, rs);
      check("rx left", d, sext(l, n));
      axr(`FAS_RXR_OFS, d, rs);
      check("rx right", d, sext(r, n));
      // Two right words unread: overrun set, right read cleared ready
      axr(`FAS_STAT_OFS, d, rs);
      check("rx ready overrun", 32'(d[1:0]), 32'h2);
      axw(`FAS_STAT_OFS, 32'h2, rs);
    end
    $display("test slave receive done");
    // Fill the FIFO to full, then drain it as master until it starves
    setup(ctrl(1'b0, 1'b1, 1'b1, 2'b00, FAS_FMT_I2S));
    for (int i = 0; i < `FAS_FIFO_DEPTH; i++)
    begin
      pushed.push_back($random(seed));
      axw(`FAS_TXD_OFS, pushed[i], rs);
    end
    axr(`FAS_STAT_OFS, d, rs);
    check("fifo full", 32'(d[4:3]), 32'h1);
    codec.got.delete();
    axw(`FAS_CTRL_OFS, ctrl(1'b1, 1'b1, 1'b1, 2'b00, FAS_FMT_I2S), rs);
    // The first two ws moves close idle slots ahead of the first load
    for (k = 0; k < 4000 && codec.got.size() < 18; k++) @(posedge clk);
    if (k == 4000) timeout_hit();
    check("sck oe master", 32'({sckOe, wsOe, sdOe}), 32'h7);
    for (int i = 0; i < 16; i++)
      check("tx word", 32'(codec.got[i + 2][7:0]), 32'(pushed[i][7:0]));
    repeat (60) @(posedge clk);
    axr(`FAS_STAT_OFS, d, rs);
    check("empty underrun", 32'({d[4], d[2]}), 32'h3);
    $display("test master transmit done");
    // Transmit drives data only in the two supported formats
    for (int f = 0; f < 5; f++)
    begin
      setup(ctrl(1'b1, 1'b1, 1'b1, 2'b00, 3'(f)));
      repeat (30) @(posedge clk);
      check("tx enable", 32'(sdOe), 32'((f == 1) || (f == 3)));
      check("master clock", 32'(sckOe), 32'h1);
    end
    $display("test formats done");
    final_report();
  end
endmodule : fm_digital_audio_serial_port_tb
`default_nettype wire
